// file: dv/adcsq_checker.sv
// Port assertions of the converter sequencer
`timescale 1ns/100ps
module adcsq_checker import adcsq_pkg::*; (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic avs_waitrequest, // Slave not ready
	input wire logic sar_done, // Conversion complete
	input wire logic [5:0] input_channel_code, // Channel
	input wire logic mux_connect, // Input connected
	input wire logic source_internal, // Internal source
	input wire logic [4:0] extra_hold_farads, // Capacitance
	input wire logic precharge_active, // Precharge
	input wire logic acquire_active, // Acquisition
	input wire logic convert_active, // Conversion
	input wire logic conversion_done_flag // Done flag
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	mux_gate_a:
	assert property (mux_connect == !(input_channel_code inside {[6'h18:6'h3a]}))
	else $error("mux connect disagrees with channel code");
	src_internal_a:
	assert property (source_internal == (input_channel_code >= 6'h3b))
	else $error("internal source flag wrong");
	phase_onehot_a:
	assert property ($onehot0({precharge_active, acquire_active, convert_active}))
	else $error("two phases active");
	conv_hold_a:
	assert property (convert_active && !sar_done && !avs_write && !$past(avs_write)
		|=> convert_active) else $error("conversion left without completion");
	done_cause_a:
	assert property ($rose(conversion_done_flag) |-> $past(convert_active) && $past(sar_done))
	else $error("done flag without completed conversion");
	wait_pulse_a:
	assert property (!avs_waitrequest |=> avs_waitrequest)
	else $error("waitrequest low too long");
	wait_answer_a:
	assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
	else $error("request not answered");
	cap_still_a:
	assert property (!$past(avs_write) |-> $stable(extra_hold_farads))
	else $error("capacitance changed without write");
	chan_still_a:
	assert property (!$past(avs_write) |-> $stable(input_channel_code))
	else $error("channel changed without write");
endmodule // adcsq_checker
bind adcsq_top adcsq_checker adcsq_checker_i (.sys_clk(sys_clk), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.sar_done(sar_done), .input_channel_code(input_channel_code), .mux_connect(mux_connect),
	.source_internal(source_internal), .extra_hold_farads(extra_hold_farads),
	.precharge_active(precharge_active), .acquire_active(acquire_active),
	.convert_active(convert_active), .conversion_done_flag(conversion_done_flag));

// file: dv/adcsq_front_model.sv
// Sampling front end model: conversion bits, completion, oscillator
`timescale 1ns/100ps
module adcsq_front_model import adcsq_pkg::*; (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic convert_active, // Conversion phase
	input wire logic [7:0] conv_len, // Cycles per conversion
	input wire logic [11:0] fe_data, // Final value
	output logic [11:0] sar_bits, // Bits so far
	output logic sar_done, // Conversion finished
	output logic rc_osc_tick // Oscillator pulse
);
	logic [7:0] cnt;
	logic [1:0] rc_cnt;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			rc_cnt <= 2'h0;
			rc_osc_tick <= 1'b0;
			sar_done <= 1'b0;
			sar_bits <= 12'h5a5;
		end else begin
			rc_cnt <= rc_cnt + 2'h1;
			rc_osc_tick <= (rc_cnt == 2'h3);
			sar_done <= 1'b0;
			if (!convert_active || sar_done) begin
				cnt <= 8'h00;
				// Undriven bits keep changing
				sar_bits <= ~sar_bits;
			end else if (cnt == conv_len) begin
				sar_done <= 1'b1;
				sar_bits <= fe_data;
			end else begin
				cnt <= cnt + 8'h01;
				// Upper bits settle first
				sar_bits <= fe_data & 12'hf00;
			end
		end
	end
endmodule // adcsq_front_model

// file: dv/adcsq_top_test.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/100ps
`include "adcsq_defines.svh"
module adcsq_top_test import adcsq_pkg::*;;
	logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, rc_osc_tick, sar_done, pre_d;
	logic threshold_event_flag, mux_connect, source_internal, precharge_active, acquire_active;
	logic precharge_level, guard_level, convert_active, converter_clock_tick;
	logic conversion_done_flag;
	logic [10:0] avs_address;
	logic [3:0] avs_byteenable, lv;
	logic [31:0] avs_writedata, avs_readdata, rv;
	logic [11:0] sar_bits, fe_data;
	logic [7:0] conv_len;
	logic [5:0] input_channel_code;
	logic [4:0] extra_hold_farads;
	int n_errors = 0, n_compared = 0, pc, ac, tk, cyc = 0;
	adcsq_top #(.ACQ_DEFAULT_CLKS(14'h0010)) adcsq_top_i (.sys_clk(sys_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rc_osc_tick(rc_osc_tick), .threshold_event_flag(threshold_event_flag),
		.sar_bits(sar_bits), .sar_done(sar_done), .input_channel_code(input_channel_code),
		.mux_connect(mux_connect), .source_internal(source_internal),
		.extra_hold_farads(extra_hold_farads), .precharge_active(precharge_active),
		.precharge_level(precharge_level), .guard_level(guard_level),
		.acquire_active(acquire_active), .convert_active(convert_active),
		.converter_clock_tick(converter_clock_tick), .conversion_done_flag(conversion_done_flag));
	adcsq_front_model adcsq_front_model_i (.sys_clk(sys_clk), .rst(rst),
		.convert_active(convert_active), .conv_len(conv_len), .fe_data(fe_data),
		.sar_bits(sar_bits), .sar_done(sar_done), .rc_osc_tick(rc_osc_tick));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Phase, tick and polarity monitors on settled values
	always @(negedge sys_clk) begin
		pc += int'(precharge_active);
		ac += int'(acquire_active);
		tk += int'(converter_clock_tick);
		if (precharge_active && !pre_d) lv = {lv[1:0], precharge_level, guard_level};
		pre_d = precharge_active;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			end_sim;
		end
	end
	task automatic end_sim;
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] ix, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge sys_clk);
		avs_address <= {ix, 2'b00};
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [8:0] ix, input logic [31:0] d);
		bus(1'b1, ix, d, 4'hf);
	endtask
	task automatic rdc(input string nm, input logic [8:0] ix, input logic [31:0] exp);
		bus(1'b0, ix, 32'h0, 4'hf);
		chk(nm, rv, exp);
	endtask
	task automatic run(input logic [31:0] ctl);
		wr(`ADCSQ_IDX_STAT, 32'h1);
		pc = 0;
		ac = 0;
		lv = 4'h0;
		wr(`ADCSQ_IDX_CTRL, ctl);
		while (conversion_done_flag !== 1'b1) @(posedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [8:0] ix[7] = '{`ADCSQ_IDX_CHAN, `ADCSQ_IDX_ACQ, `ADCSQ_IDX_CAP, `ADCSQ_IDX_PRE,
			`ADCSQ_IDX_CTRL, `ADCSQ_IDX_SAMP, 9'h100};
		foreach (ix[i]) rdc("reset value", ix[i], 32'h0);
		chk("reset mux", 32'(mux_connect), 32'h1);
		chk("no capacitance", 32'(extra_hold_farads), 32'h0);
		for (int i = 1; i < 4; i += 2) begin
			bus(1'b1, ix[i], 32'h1f00, 4'h2);
			bus(1'b1, ix[i], 32'h00ab, 4'h1);
			rdc("count bytes", ix[i], 32'h1fab);
			wr(ix[i], 32'hffff);
			rdc("count width", ix[i], 32'h1fff);
		end
		wr(`ADCSQ_IDX_CAP, 32'hff);
		@(negedge sys_clk);
		chk("capacitance", 32'(extra_hold_farads), 32'h1f);
		wr(9'h100, 32'h5);
		rdc("unmapped", 9'h100, 32'h0);
	endtask
	task automatic t_chan;
		logic [5:0] c[6] = '{6'h00, 6'h17, 6'h18, 6'h3a, 6'h3b, 6'h3f};
		foreach (c[i]) begin
			wr(`ADCSQ_IDX_CHAN, 32'(c[i]));
			@(negedge sys_clk);
			chk("connect", 32'(mux_connect), 32'(c[i] < 6'h18 || c[i] > 6'h3a));
			chk("internal", 32'(source_internal), 32'(c[i] > 6'h3a));
			chk("code pins", 32'(input_channel_code), 32'(c[i]));
			rdc("channel", `ADCSQ_IDX_CHAN, 32'(c[i]));
		end
	endtask
	task automatic t_conv;
		wr(`ADCSQ_IDX_PRE, 32'h2);
		wr(`ADCSQ_IDX_ACQ, 32'h3);
		run(32'h85);
		chk("precharge clocks", pc, 2);
		chk("acquire clocks", ac, 3);
		rdc("run cleared", `ADCSQ_IDX_CTRL, 32'h84);
		rdc("right result", `ADCSQ_IDX_RESULT, 32'h0abc);
		fe_data <= 12'h5d1;
		run(32'h81);
		rdc("left result", `ADCSQ_IDX_RESULT, 32'h5d10);
		rdc("left prior", `ADCSQ_IDX_PRIOR, 32'habc0);
		wr(`ADCSQ_IDX_ACQ, 32'h0);
		wr(`ADCSQ_IDX_PRE, 32'h1);
		run(32'h85);
		chk("default acquire", ac, 16);
		wr(`ADCSQ_IDX_PRE, 32'h0);
		run(32'h85);
		chk("no precharge", pc, 0);
		chk("no acquire", ac, 0);
	endtask
	task automatic t_double;
		wr(`ADCSQ_IDX_PRE, 32'h2);
		wr(`ADCSQ_IDX_ACQ, 32'h1);
		for (int i = 0; i < 2; i++) begin
			fe_data <= 12'h123;
			wr(`ADCSQ_IDX_SAMP, i ? 32'h81 : 32'hc1);
			fork
				run(32'h81);
				begin
					while (convert_active !== 1'b1) @(posedge sys_clk);
					while (convert_active !== 1'b0) @(posedge sys_clk);
					fe_data <= 12'h456;
				end
			join
			chk("pass levels", 32'(lv), i ? 32'ha : 32'h9);
			rdc("first in prior", `ADCSQ_IDX_PRIOR, 32'h1230);
			rdc("second in result", `ADCSQ_IDX_RESULT, 32'h4560);
		end
		wr(`ADCSQ_IDX_SAMP, 32'h0);
		wr(`ADCSQ_IDX_PRE, 32'h0);
		wr(`ADCSQ_IDX_ACQ, 32'h0);
	endtask
	task automatic t_abort;
		conv_len <= 8'h3c;
		fe_data <= 12'habc;
		wr(`ADCSQ_IDX_STAT, 32'h1);
		wr(`ADCSQ_IDX_CTRL, 32'h85);
		while (convert_active !== 1'b1) @(posedge sys_clk);
		repeat (5) @(posedge sys_clk);
		rdc("busy run", `ADCSQ_IDX_CTRL, 32'h85);
		wr(`ADCSQ_IDX_CTRL, 32'h84);
		repeat (3) @(posedge sys_clk);
		chk("aborted", 32'(convert_active), 32'h0);
		rdc("partial result", `ADCSQ_IDX_RESULT, 32'h0a00);
		rdc("no done flag", `ADCSQ_IDX_STAT, 32'h0);
		wr(`ADCSQ_IDX_CTRL, 32'h01);
		repeat (4) @(posedge sys_clk);
		rdc("disabled start", `ADCSQ_IDX_CTRL, 32'h0);
		chk("disabled idle", 32'(precharge_active | convert_active), 32'h0);
		conv_len <= 8'h03;
	endtask
	task automatic t_repeat;
		wr(`ADCSQ_IDX_AUX, 32'h80);
		run(32'hc5);
		wr(`ADCSQ_IDX_STAT, 32'h1);
		while (conversion_done_flag !== 1'b1) @(posedge sys_clk);
		rdc("repeat run", `ADCSQ_IDX_CTRL, 32'hc5);
		threshold_event_flag <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rdc("halt run", `ADCSQ_IDX_CTRL, 32'hc4);
		chk("halt idle", 32'(convert_active), 32'h0);
		threshold_event_flag <= 1'b0;
	endtask
	task automatic t_clock;
		int t0;
		wr(`ADCSQ_IDX_AUX, 32'h2);
		wr(`ADCSQ_IDX_CTRL, 32'h80);
		repeat (4) @(posedge sys_clk);
		t0 = tk;
		repeat (30) @(posedge sys_clk);
		chk("divided ticks", tk - t0, 10);
		wr(`ADCSQ_IDX_CTRL, 32'h90);
		repeat (4) @(posedge sys_clk);
		t0 = tk;
		repeat (40) @(posedge sys_clk);
		chk("oscillator ticks", tk - t0, 10);
	endtask
	initial begin
		{rst, pre_d, avs_read, avs_write, threshold_event_flag} = 5'b10000;
		{avs_address, avs_byteenable, avs_writedata} = '0;
		{pc, ac, tk} = '0;
		lv = 4'h0;
		fe_data = 12'habc;
		conv_len = 8'h03;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_chan;
		t_conv;
		t_double;
		t_abort;
		t_repeat;
		t_clock;
		end_sim;
	end
endmodule // adcsq_top_test

// file: hdl/adcsq_clkgen.sv
// Converter clock tick source: dedicated oscillator or divided system clock
`timescale 1ns/100ps
`include "adcsq_defines.svh"
module adcsq_clkgen import adcsq_pkg::*; #(
	parameter int DIV_W = 6
) (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic clk_sel, // 1 dedicated oscillator, 0 divided system clock
	input wire logic [DIV_W-1:0] div_set, // System clock divide minus one
	input wire logic rc_tick, // One pulse per dedicated oscillator period
	output logic conv_tick // One pulse per converter clock
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} adcsq_clk_state_t;

	adcsq_clk_state_t s_r;
	adcsq_clk_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (clk_sel) begin
			s_nxt.cnt = '0;
			s_nxt.tick = rc_tick;
		end else if (s_r.cnt >= div_set) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign conv_tick = s_r.tick;

endmodule // adcsq_clkgen

// file: hdl/adcsq_defines.svh
// Register offsets, field positions, reset values and counts of the converter sequencer
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

// Register indices; byte address is four times the index
`define ADCSQ_IDX_PRIOR 9'h09b
`define ADCSQ_IDX_RESULT 9'h09d
`define ADCSQ_IDX_CHAN 9'h09f
`define ADCSQ_IDX_ACQ 9'h10c
`define ADCSQ_IDX_CAP 9'h10e
`define ADCSQ_IDX_PRE 9'h10f
`define ADCSQ_IDX_CTRL 9'h111
`define ADCSQ_IDX_SAMP 9'h112
`define ADCSQ_IDX_AUX 9'h120
`define ADCSQ_IDX_STAT 9'h121

// Primary control fields
`define ADCSQ_CTRL_ENABLE 7
`define ADCSQ_CTRL_REPEAT 6
`define ADCSQ_CTRL_CLKSEL 4
`define ADCSQ_CTRL_JUSTIFY 2
`define ADCSQ_CTRL_RUN 0

// Sampling control fields
`define ADCSQ_SAMP_CHARGE_LEAD_POLARITY 7
`define ADCSQ_SAMP_INVERT_SECOND_CHARGE 6
`define ADCSQ_SAMP_GUARD_DRIVE_POLARITY 5
`define ADCSQ_SAMP_DOUBLE_SAMPLE_ENABLE 0

// Auxiliary control and status fields
`define ADCSQ_AUX_HALT 7
`define ADCSQ_STAT_DONE 0
`define ADCSQ_STAT_THRESH 1

// Channel code limits
`define ADCSQ_CHAN_LAST_PIN 6'h17
`define ADCSQ_CHAN_FIRST_INT 6'h3b

// Reset values
`define ADCSQ_RST_CHAN 6'h00
`define ADCSQ_RST_COUNT 13'h0000
`define ADCSQ_RST_CAP 5'h00
`define ADCSQ_RST_CTRL 8'h00
`define ADCSQ_RST_DIV 6'h00

// Acquisition length used when precharge is on and acquisition count is zero
`define ADCSQ_ACQ_DEFAULT 14'h2000

`endif

// file: hdl/adcsq_pkg.sv
// Types shared by the converter sequencer modules
package adcsq_pkg;

	typedef enum logic [1:0] {
		ADCSQ_IDLE,
		ADCSQ_PRE,
		ADCSQ_ACQ,
		ADCSQ_CONV
	} adcsq_phase_t;

	typedef struct packed {
		logic wait_q;
		logic [31:0] rdata;
		logic [5:0] chan;
		logic [12:0] sample_settle_count;
		logic [4:0] cap;
		logic [12:0] pre;
		logic enable;
		logic auto_rep;
		logic clk_sel;
		logic justify;
		logic run;
		logic charge_lead_polarity;
		logic invert_second_charge;
		logic guard_drive_polarity;
		logic double_sample_enable;
		logic [5:0] clkdiv;
		logic halt;
		logic done_flag;
		logic [11:0] result;
		logic [11:0] prior;
		adcsq_phase_t phase;
		logic [13:0] cnt;
		logic second;
		logic mux_on;
		logic src_int;
		logic pre_on;
		logic pre_level;
		logic guard_level;
		logic acq_on;
		logic conv_on;
	} adcsq_state_t;

endpackage

// file: hdl/adcsq_top.sv
// Converter sequencer: register file on Avalon-MM and phase control of the sampling front end
// What this block does
// - Six-bit channel code; 0x00-0x17 route port pins A, B, C in order.
// - Codes 3f, 3e fixed references; 3d DAC; 3c temperature; 3b analog ground.
// - Codes 0x18 to 0x3a are reserved and connect nothing.
// - Nonzero thirteen-bit acquisition count sets acquisition length in converter clocks.
// - Acquisition and precharge both zero: acquisition phase is skipped.
// - Precharge nonzero with acquisition zero: acquisition lasts 8192 converter clocks.
// - Thirteen-bit precharge count sets precharge length; zero removes the phase.
// - Five-bit capacitance field adds that many picofarads; zero adds none.
// - Enable bit 7 turns converter on; start only works while enabled.
// - Auto-repeat re-arms run flag until threshold halt or software clear.
// - Without auto-repeat the run flag clears when each trigger completes.
// - Clock select bit 4: dedicated oscillator, else divided system clock.
// - Justify bit 2: results right-justified, else left-justified zero-filled.
// - Writing 1 to run bit starts; reads 1 while busy, else 0.
// - Software clear mid-conversion stores partial result, resets, no done flag.
// - Acquisition and precharge counts are accessed as separate high and low bytes.
// - Double sampling does two conversions; the first lands in prior result.
// - Precharge polarity drives pin or hold capacitor to supply or ground.
// - Guard polarity sets starting guard ring level during precharge.
// - Inverted precharge flips second conversion's precharge and guard levels.
`timescale 1ns/100ps
`include "adcsq_defines.svh"
module adcsq_top import adcsq_pkg::*; #(
	parameter int ADDR_W = 11,
	parameter int DIV_W = 6,
	parameter logic [13:0] ACQ_DEFAULT_CLKS = `ADCSQ_ACQ_DEFAULT
) (
	input wire logic sys_clk, // 50 MHz system clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [3:0] avs_byteenable, // Byte lanes
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Slave not ready
	input wire logic rc_osc_tick, // Dedicated oscillator pulse
	input wire logic threshold_event_flag, // Threshold met, from neighbour
	input wire logic [11:0] sar_bits, // Conversion bits so far
	input wire logic sar_done, // Conversion complete pulse
	output logic [5:0] input_channel_code, // Multiplexer code
	output logic mux_connect, // Positive input connected
	output logic source_internal, // Selected source is internal
	output logic [4:0] extra_hold_farads, // Extra sample capacitance, pF
	output logic precharge_active, // Precharge phase
	output logic precharge_level, // 1 supply, 0 ground
	output logic guard_level, // Guard ring start level
	output logic acquire_active, // Acquisition phase
	output logic convert_active, // Conversion phase
	output logic converter_clock_tick, // Converter clock pulse
	output logic conversion_done_flag // Sticky completion flag
);

	adcsq_state_t s_r;
	adcsq_state_t s_nxt;
	logic conv_tick;

	adcsq_clkgen #(
		.DIV_W(DIV_W)
	) adcsq_clkgen_i (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_sel(s_r.clk_sel),
		.div_set(s_r.clkdiv),
		.rc_tick(rc_osc_tick),
		.conv_tick(conv_tick)
	);

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [15:0] adcsq_align(input logic [11:0] d, input logic right);
		adcsq_align = right ? {4'h0, d} : {d, 4'h0};
	endfunction

	// Routing of a channel code: {input connected, source internal}
	function automatic logic [1:0] adcsq_chan_route(input logic [5:0] code);
		adcsq_chan_route = 2'b00;
		if (code <= `ADCSQ_CHAN_LAST_PIN) begin
			adcsq_chan_route = 2'b10;
		end else if (code >= `ADCSQ_CHAN_FIRST_INT) begin
			case (code)
				6'h3f: adcsq_chan_route = 2'b11; // Second fixed reference
				6'h3e: adcsq_chan_route = 2'b11; // First fixed reference
				6'h3d: adcsq_chan_route = 2'b11; // On-chip DAC output
				6'h3c: adcsq_chan_route = 2'b11; // Temperature indicator
				6'h3b: adcsq_chan_route = 2'b11; // Analog ground
				default: adcsq_chan_route = 2'b00;
			endcase
		end else begin
			adcsq_chan_route = 2'b00;
		end
	endfunction

	// Second pass of a double sample may swap both drive levels
	function automatic logic adcsq_flip(input adcsq_state_t s);
		adcsq_flip = s.double_sample_enable && s.invert_second_charge && s.second;
	endfunction

	// Acquisition length; zero means skip the phase
	function automatic logic [13:0] adcsq_acq_len(input logic [12:0] pre,
		input logic [12:0] sample_settle_count, input logic [13:0] dflt);
		if (sample_settle_count != 13'h0000) begin
			adcsq_acq_len = {1'b0, sample_settle_count};
		end else if (pre != 13'h0000) begin
			adcsq_acq_len = dflt;
		end else begin
			adcsq_acq_len = 14'h0000;
		end
	endfunction

	function automatic logic [31:0] adcsq_read(input adcsq_state_t s,
		input logic [8:0] idx, input logic thr);
		adcsq_read = 32'h0000_0000;
		case (idx)
			`ADCSQ_IDX_PRIOR: adcsq_read = {16'h0000, adcsq_align(s.prior, s.justify)};
			`ADCSQ_IDX_RESULT: adcsq_read = {16'h0000, adcsq_align(s.result, s.justify)};
			`ADCSQ_IDX_CHAN: adcsq_read = {26'h0, s.chan};
			`ADCSQ_IDX_ACQ: adcsq_read = {19'h0, s.sample_settle_count};
			`ADCSQ_IDX_CAP: adcsq_read = {27'h0, s.cap};
			`ADCSQ_IDX_PRE: adcsq_read = {19'h0, s.pre};
			`ADCSQ_IDX_CTRL: begin
				adcsq_read[`ADCSQ_CTRL_ENABLE] = s.enable;
				adcsq_read[`ADCSQ_CTRL_REPEAT] = s.auto_rep;
				adcsq_read[`ADCSQ_CTRL_CLKSEL] = s.clk_sel;
				adcsq_read[`ADCSQ_CTRL_JUSTIFY] = s.justify;
				adcsq_read[`ADCSQ_CTRL_RUN] = s.run;
			end
			`ADCSQ_IDX_SAMP: begin
				adcsq_read[`ADCSQ_SAMP_CHARGE_LEAD_POLARITY] = s.charge_lead_polarity;
				adcsq_read[`ADCSQ_SAMP_INVERT_SECOND_CHARGE] = s.invert_second_charge;
				adcsq_read[`ADCSQ_SAMP_GUARD_DRIVE_POLARITY] = s.guard_drive_polarity;
				adcsq_read[`ADCSQ_SAMP_DOUBLE_SAMPLE_ENABLE] = s.double_sample_enable;
			end
			`ADCSQ_IDX_AUX: begin
				adcsq_read[DIV_W-1:0] = s.clkdiv;
				adcsq_read[`ADCSQ_AUX_HALT] = s.halt;
			end
			`ADCSQ_IDX_STAT: begin
				adcsq_read[`ADCSQ_STAT_DONE] = s.done_flag;
				adcsq_read[`ADCSQ_STAT_THRESH] = thr;
			end
			default: adcsq_read = 32'h0000_0000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic [8:0] idx;
	logic do_wr;
	logic [7:0] wb0;
	logic [7:0] wb1;
	logic done_set;
	logic stopping;
	logic [13:0] alen;

	assign idx = avs_address[ADDR_W-1:2];
	assign wb0 = avs_writedata[7:0];
	assign wb1 = avs_writedata[15:8];

	always_comb begin
		s_nxt = s_r;
		done_set = 1'b0;
		stopping = 1'b0;
		alen = 14'h0000;

		// Bus slave: answer one cycle after the request shows, write on the acking edge
		s_nxt.wait_q = 1'b1;
		if ((avs_read || avs_write) && s_r.wait_q) begin
			s_nxt.wait_q = 1'b0;
			s_nxt.rdata = avs_read ? adcsq_read(s_r, idx, threshold_event_flag) : 32'h0;
		end
		// Write lands on the edge that sees waitrequest low
		do_wr = avs_write && !s_r.wait_q;

		if (do_wr) begin
			case (idx)
				`ADCSQ_IDX_CHAN: begin
					if (avs_byteenable[0]) s_nxt.chan = wb0[5:0];
				end
				`ADCSQ_IDX_ACQ: begin
					if (avs_byteenable[0]) s_nxt.sample_settle_count[7:0] = wb0;
					if (avs_byteenable[1]) s_nxt.sample_settle_count[12:8] = wb1[4:0];
				end
				`ADCSQ_IDX_CAP: begin
					if (avs_byteenable[0]) s_nxt.cap = wb0[4:0];
				end
				`ADCSQ_IDX_PRE: begin
					if (avs_byteenable[0]) s_nxt.pre[7:0] = wb0;
					if (avs_byteenable[1]) s_nxt.pre[12:8] = wb1[4:0];
				end
				`ADCSQ_IDX_CTRL: begin
					if (avs_byteenable[0]) begin
						s_nxt.enable = wb0[`ADCSQ_CTRL_ENABLE];
						s_nxt.auto_rep = wb0[`ADCSQ_CTRL_REPEAT];
						s_nxt.clk_sel = wb0[`ADCSQ_CTRL_CLKSEL];
						s_nxt.justify = wb0[`ADCSQ_CTRL_JUSTIFY];
						// Start ignored while the converter is off
						s_nxt.run = wb0[`ADCSQ_CTRL_RUN] && wb0[`ADCSQ_CTRL_ENABLE];
					end
				end
				`ADCSQ_IDX_SAMP: begin
					if (avs_byteenable[0]) begin
						s_nxt.charge_lead_polarity = wb0[`ADCSQ_SAMP_CHARGE_LEAD_POLARITY];
						s_nxt.invert_second_charge = wb0[`ADCSQ_SAMP_INVERT_SECOND_CHARGE];
						s_nxt.guard_drive_polarity = wb0[`ADCSQ_SAMP_GUARD_DRIVE_POLARITY];
						s_nxt.double_sample_enable = wb0[`ADCSQ_SAMP_DOUBLE_SAMPLE_ENABLE];
					end
				end
				`ADCSQ_IDX_AUX: begin
					if (avs_byteenable[0]) begin
						s_nxt.clkdiv = wb0[DIV_W-1:0];
						s_nxt.halt = wb0[`ADCSQ_AUX_HALT];
					end
				end
				`ADCSQ_IDX_STAT: begin
					if (avs_byteenable[0] && wb0[`ADCSQ_STAT_DONE]) s_nxt.done_flag = 1'b0;
				end
				default: ;
			endcase
		end

		// Phase sequencer
		// Next-state counts, so a write and a start may share an edge
		alen = adcsq_acq_len(s_nxt.pre, s_nxt.sample_settle_count, ACQ_DEFAULT_CLKS);
		case (s_r.phase)
			ADCSQ_IDLE: begin
				if (s_nxt.run && s_nxt.enable) begin
					s_nxt.second = 1'b0;
					// Single sample: prior keeps the result that stood at the start
					if (!s_nxt.double_sample_enable) s_nxt.prior = s_r.result;
					stopping = 1'b1;
				end
			end
			ADCSQ_PRE, ADCSQ_ACQ: begin
				// Cleared or disabled: back to idle, nothing stored
				if (!s_nxt.run || !s_nxt.enable) begin
					s_nxt.phase = ADCSQ_IDLE;
				end else if (conv_tick) begin
					if (s_r.cnt <= 14'h0001) begin
						if (s_r.phase == ADCSQ_PRE && alen != 14'h0000) begin
							s_nxt.phase = ADCSQ_ACQ;
							s_nxt.cnt = alen;
						end else begin
							s_nxt.phase = ADCSQ_CONV;
						end
					end else begin
						s_nxt.cnt = s_r.cnt - 14'h0001;
					end
				end
			end
			ADCSQ_CONV: begin
				// Cleared mid-conversion: partial bits kept, no completion flag
				if (!s_nxt.run || !s_nxt.enable) begin
					s_nxt.result = sar_bits;
					s_nxt.phase = ADCSQ_IDLE;
				end else if (sar_done) begin
					// First pass of a double sample: restart at the first phase that has a nonzero length
					if (s_r.double_sample_enable && !s_r.second) begin
						s_nxt.prior = sar_bits;
						s_nxt.second = 1'b1;
						stopping = 1'b1;
					end else begin
						s_nxt.result = sar_bits;
						done_set = 1'b1;
						s_nxt.second = 1'b0;
						// Threshold halt only ends a repeating run
						if (s_r.auto_rep && !(s_r.halt && threshold_event_flag)) begin
							s_nxt.run = 1'b1;
							if (!s_r.double_sample_enable) s_nxt.prior = sar_bits;
							stopping = 1'b1;
						end else begin
							s_nxt.run = 1'b0;
							s_nxt.phase = ADCSQ_IDLE;
						end
					end
				end
			end
			default: s_nxt.phase = ADCSQ_IDLE;
		endcase

		// Begin a conversion pass: first phase that has a nonzero length
		if (stopping) begin
			if (s_nxt.pre != 13'h0000) begin
				s_nxt.phase = ADCSQ_PRE;
				s_nxt.cnt = {1'b0, s_nxt.pre};
			end else if (alen != 14'h0000) begin
				s_nxt.phase = ADCSQ_ACQ;
				s_nxt.cnt = alen;
			end else begin
				s_nxt.phase = ADCSQ_CONV;
			end
		end

		// Completion flag: hardware set wins over software clear
		if (done_set) s_nxt.done_flag = 1'b1;

		// Front-end drive, registered from the next state
		{s_nxt.mux_on, s_nxt.src_int} = adcsq_chan_route(s_nxt.chan);
		s_nxt.pre_on = s_nxt.phase == ADCSQ_PRE;
		// Levels reach the pins in every phase, not only while precharge is active
		s_nxt.pre_level = s_nxt.charge_lead_polarity ^ adcsq_flip(s_nxt);
		s_nxt.guard_level = s_nxt.guard_drive_polarity ^ adcsq_flip(s_nxt);
		s_nxt.acq_on = s_nxt.phase == ADCSQ_ACQ;
		s_nxt.conv_on = s_nxt.phase == ADCSQ_CONV;
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.wait_q <= 1'b1;
			s_r.chan <= `ADCSQ_RST_CHAN;
			s_r.sample_settle_count <= `ADCSQ_RST_COUNT;
			s_r.pre <= `ADCSQ_RST_COUNT;
			s_r.cap <= `ADCSQ_RST_CAP;
			s_r.clkdiv <= `ADCSQ_RST_DIV;
			s_r.phase <= ADCSQ_IDLE;
			s_r.mux_on <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign avs_readdata = s_r.rdata;
	assign avs_waitrequest = s_r.wait_q;
	assign input_channel_code = s_r.chan;
	assign mux_connect = s_r.mux_on;
	assign source_internal = s_r.src_int;
	assign extra_hold_farads = s_r.cap;
	assign precharge_active = s_r.pre_on;
	assign precharge_level = s_r.pre_level;
	assign guard_level = s_r.guard_level;
	assign acquire_active = s_r.acq_on;
	assign convert_active = s_r.conv_on;
	assign converter_clock_tick = conv_tick;
	assign conversion_done_flag = s_r.done_flag;

endmodule // adcsq_top
